/* File: logic/drvtest_pkg.sv */
// Package: register map, field layout, timing and types of the driver test block
package drvtest_pkg;

  // Register index as printed; byte address is four times the index
  localparam logic [7:0]  REG_IDX           = 8'h1B;
  localparam logic [11:0] REG_ADDR          = {2'b00, REG_IDX, 2'b00};
  localparam int          ADDR_W            = 12;
  localparam int          DATA_W            = 32;

  // Field positions
  localparam int          TALLY_LSB         = 8;
  localparam int          TALLY_MSB         = 15;
  localparam int          SPARE7_BIT        = 7;
  localparam int          CLK_FORCE_BIT     = 6;
  localparam int          NONSTOP_BIT       = 5;
  localparam int          PAT_EN_BIT        = 4;
  localparam int          PULLUP_BIT        = 3;
  localparam int          SPACING_BIT       = 2;
  localparam int          PICK_LSB          = 0;
  localparam int          PICK_MSB          = 1;

  // Reset values and tally maximum
  localparam logic [7:0]  TALLY_RST         = 8'h00;
  localparam logic [7:0]  TALLY_MAX         = 8'hFF;
  localparam logic        CTRL_BIT_RST      = 1'b0;
  localparam logic [1:0]  PICK_RST          = 2'b00;

  // Timing: clock period and gap times in ns, counts derived
  localparam int          CLK_PERIOD_NS     = 4;
  localparam int          GAP_SHORT_NS      = 10000;
  localparam int          GAP_LONG_NS       = 15000;
  localparam int          GAP_CNT_W         = 12;
  localparam logic [GAP_CNT_W-1:0] GAP_SHORT_CYC = GAP_CNT_W'(GAP_SHORT_NS / CLK_PERIOD_NS);
  localparam logic [GAP_CNT_W-1:0] GAP_LONG_CYC  = GAP_CNT_W'(GAP_LONG_NS / CLK_PERIOD_NS);

  // Driver pattern encodings
  typedef enum logic [1:0] {
    PICK_DATA_END_FIRST  = 2'b00,
    PICK_DATA_END_SECOND = 2'b01,
    PICK_LINK_PULSE      = 2'b10,
    PICK_SINE_TONE       = 2'b11
  } pattern_pick_e;

  // APB request from the master
  typedef struct packed {
    logic              psel;
    logic              penable;
    logic              pwrite;
    logic [ADDR_W-1:0] paddr;
    logic [DATA_W-1:0] pwdata;
  } apb_req_s;

  // APB answer to the master
  typedef struct packed {
    logic              pready;
    logic [DATA_W-1:0] prdata;
    logic              pslverr;
  } apb_rsp_s;

endpackage : drvtest_pkg

/* File: logic/fault_tally.sv */
// Saturating tally of errored receive nibbles during packet self test
`timescale 1ns/1ns
`default_nettype none
module fault_tally (
  // Clock and reset
  input  wire logic       pclk,
  input  wire logic       presetn,
  // Control
  input  wire logic       clear,
  input  wire logic       bump,
  // Count
  output logic [7:0]      count
);
  import drvtest_pkg::*;

  logic [7:0] count_q;  // Running tally
  logic [7:0] count_d;  // Next tally

  // Clear restarts from zero, but a bump in the same cycle still counts
  always_comb begin
    count_d = count_q;
    if (clear) begin
      count_d = bump ? 8'h01 : TALLY_RST;
    end else if (bump && (count_q != TALLY_MAX)) begin
      count_d = count_q + 8'h01;
    end
  end

  // Register stage
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count_q <= TALLY_RST;
    end else begin
      count_q <= count_d;
    end
  end

  assign count = count_q;

endmodule : fault_tally
`default_nettype wire

/* File: logic/gap_timer.sv */
// Down counter that times the quiet gap between driver test sequences
`timescale 1ns/1ns
`default_nettype none
module gap_timer (
  // Clock and reset
  input  wire logic       pclk,
  input  wire logic       presetn,
  // Control
  input  wire logic       start,
  input  wire logic       long_gap,
  input  wire logic       abort,
  // Status
  output logic            busy,
  output logic            done
);
  import drvtest_pkg::*;

  logic [GAP_CNT_W-1:0] cnt_q;   // Cycles left in the gap
  logic [GAP_CNT_W-1:0] cnt_d;
  logic                 busy_q;  // Gap in progress
  logic                 busy_d;

  // Load on start; last cycle of the gap is the one where the count is zero
  always_comb begin
    cnt_d  = cnt_q;
    busy_d = busy_q;
    if (abort) begin
      busy_d = 1'b0;
    end else if (start) begin
      cnt_d  = (long_gap ? GAP_LONG_CYC : GAP_SHORT_CYC) - GAP_CNT_W'(1);
      busy_d = 1'b1;
    end else if (busy_q) begin
      if (cnt_q == '0) begin
        busy_d = 1'b0;
      end else begin
        cnt_d = cnt_q - GAP_CNT_W'(1);
      end
    end
  end

  // Register stage
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q  <= '0;
      busy_q <= 1'b0;
    end else begin
      cnt_q  <= cnt_d;
      busy_q <= busy_d;
    end
  end

  assign busy = busy_q;
  assign done = busy_q && (cnt_q == '0) && !abort;

endmodule : gap_timer
`default_nettype wire

/* File: logic/driver_test_selftest_ext.sv */
// Driver test and self-test extension register with its pattern sequencer
//
// Local design decision: register access over APB.
`timescale 1ns/1ns
`default_nettype none

// Notes on behaviour
// R01: Count errored nibbles into read-only upper byte
// R02: Self-test restart clears the fault tally
// R03: Tally sticks at FFh, never wraps
// R04: Clock force bit drives both media clocks
// R05: RMII slave default keeps media clocks off
// R06: Nonstop bit gives continuous pseudorandom transmit
// R07: Software disables babble guard before 10Mb nonstop
// R08: Pattern enable replaces normal 10Mb driver output
// R09: Pull-up bit enables pull-up; hardware reset only
// R10: Shared management bus: leave pull-up off
// R11: Gap between sequences 15us or 10us
// R12: Pick field selects data, pulses or tone
// R13: Tally counts only while self test checks
module driver_test_selftest_ext (
  // Clock and reset
  input  wire logic                  pclk,
  input  wire logic                  presetn,
  // APB slave
  input  wire drvtest_pkg::apb_req_s apb_req,
  output var  drvtest_pkg::apb_rsp_s apb_rsp,
  // Device-wide soft reset pulse
  input  wire logic                  soft_reset,
  // Packet self test status from the main control logic
  input  wire logic                  selftest_start,
  input  wire logic                  selftest_run,
  input  wire logic                  selftest_checking,
  input  wire logic                  nibble_error,
  // MAC interface mode
  input  wire logic                  rmii_slave_mode,
  // Line driver handshake
  input  wire logic                  drv_seq_done,
  // Media clock enables
  output logic                       tx_clk_en,
  output logic                       rx_clk_en,
  // Management line pull-up
  output logic                       mgmt_pullup_en,
  // Self-test transmitter control
  output logic                       nonstop_tx,
  // Driver pattern control
  output logic                       drv_pattern_override,
  output logic [1:0]                 drv_pattern_kind,
  output logic                       drv_seq_go,
  output logic                       drv_in_gap
);
  import drvtest_pkg::*;

  typedef enum logic [1:0] {PAT_IDLE, PAT_SEND, PAT_GAP} pat_state_e;

  // Software control bits
  logic       spare7_q, spare7_d;              // Reserved, stored as written
  logic       clk_force_q, clk_force_d;        // Media clock force
  logic       nonstop_q, nonstop_d;            // Self-test nonstop mode
  logic       pat_en_q, pat_en_d;              // Driver pattern enable
  logic       pullup_q, pullup_d;              // Management pull-up
  logic       spacing_q, spacing_d;            // Long gap select
  logic [1:0] pick_q, pick_d;                  // Driver pattern pick

  // APB answer state
  apb_rsp_s   rsp_q, rsp_d;                    // Registered answer
  logic       hit;                             // Address decodes to our register
  logic       do_write;                        // Write completes this edge
  logic [15:0] reg_view;                       // Register as read

  // Fault tally
  logic [7:0] tally;                           // Saturating error count
  logic       tally_bump;                      // Qualified error

  // Pattern sequencer
  pat_state_e pat_q, pat_d;                    // Sequencer state
  logic       go_q, go_d;                      // Sequence start pulse
  logic       gap_start;                       // Enter gap
  logic       gap_long_q, gap_long_d;          // Gap length latched at start
  logic       gap_busy;                        // Timer running
  logic       gap_done;                        // Last gap cycle
  logic       pat_abort;                       // Pattern switched off

  // Outputs
  logic       tx_clk_q, tx_clk_d;
  logic       rx_clk_q, rx_clk_d;
  logic       nonstop_tx_q, nonstop_tx_d;
  logic       override_q, override_d;
  logic [1:0] kind_q, kind_d;
  logic       in_gap_q, in_gap_d;

  // Decode; a write lands only at the edge that sees pready high
  assign hit      = (apb_req.paddr == REG_ADDR);
  assign do_write = apb_req.psel && apb_req.penable && rsp_q.pready && apb_req.pwrite && hit;
  assign reg_view = {tally, spare7_q, clk_force_q, nonstop_q, pat_en_q, pullup_q, spacing_q, pick_q};

  // APB answer: one wait state so every answer comes from a flop
  always_comb begin
    rsp_d = '0;
    if (apb_req.psel && apb_req.penable && !rsp_q.pready) begin
      rsp_d.pready  = 1'b1;
      rsp_d.pslverr = !hit;                    // Unmapped address errors
      if (!apb_req.pwrite && hit) begin
        rsp_d.prdata = {16'h0000, reg_view};
      end
    end
  end

  // Control bits: writes, and soft reset that spares the pull-up bit
  always_comb begin
    spare7_d    = spare7_q;
    clk_force_d = clk_force_q;
    nonstop_d   = nonstop_q;
    pat_en_d    = pat_en_q;
    pullup_d    = pullup_q;
    spacing_d   = spacing_q;
    pick_d      = pick_q;
    if (soft_reset) begin
      // Pull-up survives soft reset; only presetn or a write of zero clears it
      spare7_d    = CTRL_BIT_RST;
      clk_force_d = CTRL_BIT_RST;
      nonstop_d   = CTRL_BIT_RST;
      pat_en_d    = CTRL_BIT_RST;
      spacing_d   = CTRL_BIT_RST;
      pick_d      = PICK_RST;              // R09
    end else if (do_write) begin
      spare7_d    = apb_req.pwdata[SPARE7_BIT];
      clk_force_d = apb_req.pwdata[CLK_FORCE_BIT];
      nonstop_d   = apb_req.pwdata[NONSTOP_BIT];
      pat_en_d    = apb_req.pwdata[PAT_EN_BIT];
      spacing_d   = apb_req.pwdata[SPACING_BIT];
      pick_d      = apb_req.pwdata[PICK_MSB:PICK_LSB];
    end
    if (do_write && !soft_reset) begin
      pullup_d = apb_req.pwdata[PULLUP_BIT];   // R09
    end
  end

  // Register stage for control bits and the bus answer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      spare7_q    <= CTRL_BIT_RST;
      clk_force_q <= CTRL_BIT_RST;
      nonstop_q   <= CTRL_BIT_RST;
      pat_en_q    <= CTRL_BIT_RST;
      pullup_q    <= CTRL_BIT_RST;
      spacing_q   <= CTRL_BIT_RST;
      pick_q      <= PICK_RST;
      rsp_q       <= '0;
    end else begin
      spare7_q    <= spare7_d;
      clk_force_q <= clk_force_d;
      nonstop_q   <= nonstop_d;
      pat_en_q    <= pat_en_d;
      pullup_q    <= pullup_d;
      spacing_q   <= spacing_d;
      pick_q      <= pick_d;
      rsp_q       <= rsp_d;
    end
  end

  // Errors outside the checking window are dropped
  assign tally_bump = nibble_error && selftest_checking;   // R13

  // Saturating counter, cleared on each self-test start
  fault_tally u_tally (
    .pclk    (pclk),
    .presetn (presetn),
    .clear   (selftest_start),                 // R02
    .bump    (tally_bump),                     // R01 R03
    .count   (tally)
  );

  // Gap timer; sine tone never pauses, so it never starts the timer
  assign pat_abort = !pat_en_q;
  assign gap_start = (pat_q == PAT_SEND) && drv_seq_done && pat_en_q && (pick_q != PICK_SINE_TONE);

  gap_timer u_gap (
    .pclk     (pclk),
    .presetn  (presetn),
    .start    (gap_start),
    .long_gap (spacing_q),                     // R11
    .abort    (pat_abort),
    .busy     (gap_busy),
    .done     (gap_done)
  );

  // Pattern sequencer: send, wait for the driver, rest, send again
  always_comb begin
    pat_d      = pat_q;
    go_d       = 1'b0;
    gap_long_d = gap_long_q;
    case (pat_q)
      PAT_IDLE: begin
        if (pat_en_q) begin
          pat_d = PAT_SEND;
          go_d  = 1'b1;                        // R08
        end
      end
      PAT_SEND: begin
        if (!pat_en_q) begin
          pat_d = PAT_IDLE;
        end else if (gap_start) begin
          pat_d      = PAT_GAP;
          gap_long_d = spacing_q;              // R11
        end
      end
      PAT_GAP: begin
        if (!pat_en_q) begin
          pat_d = PAT_IDLE;
        end else if (gap_done) begin
          pat_d = PAT_SEND;
          go_d  = 1'b1;
        end
      end
      default: begin
        pat_d = PAT_IDLE;
      end
    endcase
  end

  // Output decisions, all registered
  always_comb begin
    // Forced clocks win; otherwise RMII slave keeps them off
    tx_clk_d     = clk_force_q || !rmii_slave_mode;          // R04 R05
    rx_clk_d     = clk_force_q || !rmii_slave_mode;          // R04 R05
    // Nonstop only matters while self test itself runs
    nonstop_tx_d = nonstop_q && selftest_run;                // R06
    override_d   = pat_en_q;                                 // R08
    kind_d       = pat_en_q ? pick_q : PICK_DATA_END_FIRST;  // R12
    in_gap_d     = (pat_d == PAT_GAP);
  end

  // Register stage for sequencer and outputs
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pat_q        <= PAT_IDLE;
      go_q         <= 1'b0;
      gap_long_q   <= 1'b0;
      tx_clk_q     <= 1'b0;
      rx_clk_q     <= 1'b0;
      nonstop_tx_q <= 1'b0;
      override_q   <= 1'b0;
      kind_q       <= PICK_RST;
      in_gap_q     <= 1'b0;
    end else begin
      pat_q        <= pat_d;
      go_q         <= go_d;
      gap_long_q   <= gap_long_d;
      tx_clk_q     <= tx_clk_d;
      rx_clk_q     <= rx_clk_d;
      nonstop_tx_q <= nonstop_tx_d;
      override_q   <= override_d;
      kind_q       <= kind_d;
      in_gap_q     <= in_gap_d;
    end
  end

  // Port drives
  assign apb_rsp              = rsp_q;
  assign tx_clk_en            = tx_clk_q;
  assign rx_clk_en            = rx_clk_q;
  assign mgmt_pullup_en       = pullup_q;                    // R09
  assign nonstop_tx           = nonstop_tx_q;
  assign drv_pattern_override = override_q;
  assign drv_pattern_kind     = kind_q;
  assign drv_seq_go           = go_q;
  assign drv_in_gap           = in_gap_q;

  // Helper: cycles spent in the current gap, read only by checks
  logic [GAP_CNT_W-1:0] gap_seen_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gap_seen_q <= '0;
    end else begin
      gap_seen_q <= (pat_q == PAT_GAP) ? gap_seen_q + GAP_CNT_W'(1) : '0;
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence access_wait_s;
    apb_req.psel && apb_req.penable && !rsp_q.pready;
  endsequence

  sequence restart_quiet_s;
    selftest_start && !tally_bump;
  endsequence

  apb_answer_a: assert property (access_wait_s |=> apb_rsp.pready)
    else $error("APB answer missing after wait state");
  tally_count_a: assert property (tally_bump && !selftest_start && tally != TALLY_MAX |=> tally == $past(tally) + 8'h01) // R01
    else $error("Tally did not count an error");
  tally_clear_a: assert property (restart_quiet_s |=> tally == TALLY_RST) // R02
    else $error("Tally not cleared on restart");
  tally_sat_a: assert property (tally == TALLY_MAX && !selftest_start |=> tally == TALLY_MAX) // R03
    else $error("Tally wrapped past maximum");
  tally_idle_a: assert property (!selftest_checking && !selftest_start |=> $stable(tally)) // R13
    else $error("Tally moved outside checking");
  clk_force_a: assert property (clk_force_q |=> tx_clk_en && rx_clk_en) // R04
    else $error("Forced clocks not enabled");
  clk_rmii_a: assert property (!clk_force_q && rmii_slave_mode |=> !tx_clk_en && !rx_clk_en) // R05
    else $error("Clocks on in RMII slave default");
  nonstop_tx_a: assert property (nonstop_q && selftest_run |=> nonstop_tx) // R06
    else $error("Nonstop transmit not asserted");
  pattern_off_a: assert property (!pat_en_q |=> !drv_pattern_override && pat_q == PAT_IDLE) // R08
    else $error("Pattern override left on");
  pattern_kind_a: assert property (pat_en_q |=> drv_pattern_kind == $past(pick_q)) // R12
    else $error("Pattern kind does not follow pick");
  pullup_soft_a: assert property (soft_reset |=> $stable(pullup_q) && mgmt_pullup_en == pullup_q) // R09
    else $error("Pull-up changed on soft reset");
  gap_short_a: assert property (gap_done && !gap_long_q && pat_q == PAT_GAP |-> gap_seen_q == GAP_SHORT_CYC - 12'd1) // R11
    else $error("Short gap length wrong");
  gap_long_a: assert property (gap_done && gap_long_q && pat_q == PAT_GAP |-> gap_seen_q == GAP_LONG_CYC - 12'd1) // R11
    else $error("Long gap length wrong");
  gap_busy_a: assert property ((pat_q == PAT_GAP) == gap_busy) // R11
    else $error("Gap timer and sequencer disagree");

endmodule : driver_test_selftest_ext
`default_nettype wire

/* File: dv/tb.sv */
// Self-checking bench for the driver test and self-test extension register
`timescale 1ns/1ns
`default_nettype none
module tb;
  import drvtest_pkg::*;

  // Clock, reset and design inputs
  logic     pclk;
  logic     presetn;
  apb_req_s req;
  apb_rsp_s rsp;
  logic     soft_reset;
  logic     st_start;
  logic     st_run;
  logic     st_chk;
  logic     nib_err;
  logic     rmii_slave;
  logic     seq_done;
  // Design outputs
  logic       tx_en;
  logic       rx_en;
  logic       pull_en;
  logic       nonstop;
  logic       ovr;
  logic [1:0] kind;
  logic       go;
  logic       in_gap;
  // Scoreboard
  int          miscompares;
  int          samples_checked;
  logic [31:0] rd;
  logic        err;
  int          cnt;

  driver_test_selftest_ext i_dut (
    .pclk                 (pclk),
    .presetn              (presetn),
    .apb_req              (req),
    .apb_rsp              (rsp),
    .soft_reset           (soft_reset),
    .selftest_start       (st_start),
    .selftest_run         (st_run),
    .selftest_checking    (st_chk),
    .nibble_error         (nib_err),
    .rmii_slave_mode      (rmii_slave),
    .drv_seq_done         (seq_done),
    .tx_clk_en            (tx_en),
    .rx_clk_en            (rx_en),
    .mgmt_pullup_en       (pull_en),
    .nonstop_tx           (nonstop),
    .drv_pattern_override (ovr),
    .drv_pattern_kind     (kind),
    .drv_seq_go           (go),
    .drv_in_gap           (in_gap)
  );

  // Free-running 250 MHz clock
  initial begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end

  // Verdict and end of run, also reached by an exhausted APB or go wait
  task automatic stop_test;
    $display("checks %0d, mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : stop_test

  // One comparison; four-state so an unknown never matches
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch at %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  // Exhausted bound counts as a mismatch and closes the run
  task automatic hang;
    miscompares++;
    $display("mismatch at %0t got %h exp %h", $time, 32'h0000_0000, 32'h0000_0001);
    stop_test();
  endtask : hang

  task automatic cyc(input int n);
    repeat (n) @(posedge pclk);
  endtask : cyc

  // APB transfer: hold request until pready is sampled high
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
    int n;
    @(posedge pclk);
    req.psel    <= 1'b1;
    req.penable <= 1'b0;
    req.pwrite  <= wr;
    req.paddr   <= a;
    req.pwdata  <= wd;
    @(posedge pclk);
    req.penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (rsp.pready !== 1'b1 && n < 50);
    if (n >= 50) hang();
    rd = rsp.prdata;
    err = rsp.pslverr;
    req.psel    <= 1'b0;
    req.penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [31:0] d);
    apb(1'b1, REG_ADDR, d);
    chk({31'h0, err}, 32'h0000_0000);
  endtask : wr

  task automatic rd_chk(input logic [31:0] exp);
    apb(1'b0, REG_ADDR, 32'h0000_0000);
    chk(rd, exp);
  endtask : rd_chk

  // Errored nibbles, one per cycle
  task automatic errs(input int n);
    repeat (n) begin
      @(posedge pclk);
      nib_err <= 1'b1;
    end
    @(posedge pclk);
    nib_err <= 1'b0;
  endtask : errs

  // A pulse already standing at the call counts; the gap task ends on its edge
  task automatic wait_go;
    int n;
    n = 0;
    while (go !== 1'b1 && n < 100) begin
      @(posedge pclk);
      n++;
    end
    if (go !== 1'b1) hang();
  endtask : wait_go

  // Finish a sequence and count the gap cycles that follow
  task automatic gap(input int lim, output int c);
    @(posedge pclk);
    seq_done <= 1'b1;
    @(posedge pclk);
    seq_done <= 1'b0;
    c = 0;
    for (int i = 0; i < lim; i++) begin
      @(posedge pclk);
      if (in_gap === 1'b1) c++;
      else if (c > 0) break;
    end
  endtask : gap

  initial begin
    req = '0;
    presetn = 1'b0;
    soft_reset = 1'b0;
    st_start = 1'b0;
    st_run = 1'b0;
    st_chk = 1'b0;
    nib_err = 1'b0;
    rmii_slave = 1'b1;
    seq_done = 1'b0;
    miscompares = 0;
    samples_checked = 0;
    cyc(12);
    presetn <= 1'b1;

    // Reset value, read-only tally, upper half zero, unmapped place
    rd_chk(32'h0000_0000);
    wr(32'hFFFF_FF7F);
    rd_chk(32'h0000_007F);
    apb(1'b1, REG_ADDR + 12'h004, 32'h0000_0000);
    chk({31'h0, err}, 32'h0000_0001);
    apb(1'b0, REG_ADDR + 12'h004, 32'h0000_0000);
    chk(rd, 32'h0000_0000);
    rd_chk(32'h0000_007F);
    $display("test registers done");

    // Soft reset keeps only the pull-up bit
    cyc(2);
    chk({31'h0, pull_en}, 32'h0000_0001);
    @(posedge pclk);
    soft_reset <= 1'b1;
    @(posedge pclk);
    soft_reset <= 1'b0;
    rd_chk(32'h0000_0008);
    chk({31'h0, pull_en}, 32'h0000_0001);
    wr(32'h0000_0000);
    cyc(2);
    chk({31'h0, pull_en}, 32'h0000_0000);
    $display("test soft reset done");

    // Media clocks: slave default off, forced on, other modes on
    chk({30'h0, tx_en, rx_en}, 32'h0000_0000);
    wr(32'h0000_0040);
    cyc(2);
    chk({30'h0, tx_en, rx_en}, 32'h0000_0003);
    wr(32'h0000_0000);
    @(posedge pclk);
    rmii_slave <= 1'b0;
    cyc(2);
    chk({30'h0, tx_en, rx_en}, 32'h0000_0003);
    rmii_slave <= 1'b1;
    $display("test clocks done");

    // Nonstop transmit needs the bit and a running self test
    wr(32'h0000_0020);
    st_run <= 1'b1;
    cyc(2);
    chk({31'h0, nonstop}, 32'h0000_0001);
    st_run <= 1'b0;
    cyc(2);
    chk({31'h0, nonstop}, 32'h0000_0000);
    $display("test nonstop done");

    // Every pattern pick, then pattern off
    for (int p = 0; p < 4; p++) begin
      wr(32'h0000_0010 | p);
      cyc(2);
      chk({29'h0, ovr, kind}, 32'h0000_0004 | p);
    end
    wr(32'h0000_0003);
    cyc(2);
    chk({29'h0, ovr, kind}, 32'h0000_0000);
    wr(32'h0000_0000);
    $display("test patterns done");

    // Fault tally: gated, counted, saturating, cleared on restart
    @(posedge pclk);
    st_start <= 1'b1;
    @(posedge pclk);
    st_start <= 1'b0;
    errs(3);
    rd_chk(32'h0000_0000);
    st_chk <= 1'b1;
    errs(5);
    rd_chk(32'h0000_0500);
    errs(300);
    rd_chk({16'h0, TALLY_MAX, 8'h00});
    @(posedge pclk);
    st_start <= 1'b1;
    @(posedge pclk);
    st_start <= 1'b0;
    rd_chk(32'h0000_0000);
    @(posedge pclk);
    st_start <= 1'b1;
    nib_err  <= 1'b1;
    @(posedge pclk);
    st_start <= 1'b0;
    nib_err  <= 1'b0;
    rd_chk(32'h0000_0100);
    st_chk <= 1'b0;
    $display("test tally done");

    // Gap lengths between driver test sequences
    wr(32'h0000_0010);
    wait_go();
    gap(5000, cnt);
    chk(cnt, 32'(GAP_SHORT_CYC));
    wait_go();
    wr(32'h0000_0014);
    gap(5000, cnt);
    chk(cnt, 32'(GAP_LONG_CYC));
    wait_go();
    wr(32'h0000_0013);
    gap(20, cnt);
    chk(cnt, 32'h0000_0000);
    $display("test gaps done");
    stop_test();
  end
endmodule : tb
`default_nettype wire
